// File: hdl/dbgs_pkg.sv
/*
 * constants, field layout and state type of the debug sequencer.
 * assumes a 32-bit apb slave and word-aligned registers.
 */
package dbgs_pkg;
   // apb address and data shape
   localparam int          DBGS_AW        = 12;
   localparam int          DBGS_DW        = 32;
   localparam int          DBGS_RW        = 8;      // stored register width
   localparam int          DBGS_NCH       = 3;      // match channels 0..2
   // register indices, byte address is four times the index
   localparam logic [9:0]  IDX_CTRL       = 10'h020;
   localparam logic [9:0]  IDX_STATUS     = 10'h021;
   localparam logic [9:0]  IDX_SEL2       = 10'h026;
   localparam logic [9:0]  IDX_SEL3       = 10'h027;
   localparam logic [9:0]  IDX_CMPEN      = 10'h028;
   // control register fields
   localparam int          CTRL_ARM_BIT   = 0;
   localparam int          CTRL_VIEW_LSB  = 1;
   localparam int          CTRL_VIEW_MSB  = 2;
   localparam logic [1:0]  VIEW_SEL3      = 2'h2;
   // next-state code field
   localparam int          CODE_MSB       = 3;
   // reset values
   localparam logic [7:0]  CTRL_RST       = 8'h00;
   localparam logic [7:0]  SEL2_RST       = 8'h00;
   localparam logic [7:0]  SEL3_RST       = 8'h00;
   localparam logic [2:0]  CMPEN_RST      = 3'h0;
   // state2 codes
   localparam logic [3:0]  NS2_M2_FIN     = 4'h5;
   localparam logic [3:0]  NS2_M2S1_M0FIN = 4'h6;
   localparam logic [3:0]  NS2_M01_FIN    = 4'h7;
   localparam logic [3:0]  NS2_M01F_M2S3  = 4'hC;
   localparam logic [3:0]  NS2_M01F_M2S1  = 4'hF;
   // state3 codes
   localparam logic [3:0]  NS3_M0_S1      = 4'h0;
   // sequencer states
   typedef enum logic [1:0] {
      DBGS_STATE1,
      DBGS_STATE2,
      DBGS_STATE3,
      DBGS_FINAL
   } dbgs_state_t;
endpackage : dbgs_pkg

// File: hdl/dbgs_sequencer.sv
/*
 * debug state sequencer with its apb register file.
 * assumes match pulses come from logic on the same clock, one per channel.
 */
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - state2 code 0101: match2 goes final
// - code 0110: match2 to state1, match0 final
// - code 0111: match0 or match1 goes final
// - code 1100: match0/1 final, match2 to state3
// - code 1111: match0/1 final, match2 to state1
// - unnamed matches leave the state unchanged
// - final target first, then lowest channel
// - state3 select readable only when view is 10
// - state3 select writable when view 10, unarmed
// - state3 code 0000: match0 goes to state1
module dbgs_sequencer
   import dbgs_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [DBGS_AW-1:0]   paddr,
   input  wire logic [DBGS_DW-1:0]   pwdata,
   output logic      [DBGS_DW-1:0]   prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [DBGS_NCH-1:0]  matchEvent,
   output logic      [1:0]           seqState,
   output logic                      armed
);
   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [7:0]           ctrl_q,    ctrl_d;     // arm bit and view field
   logic [DBGS_NCH-1:0]  cmpEn_q,   cmpEn_d;    // per-comparator enables
   logic [7:0]           sel2_q,    sel2_d;     // state2 select
   logic [7:0]           sel3_q,    sel3_d;     // state3 select
   logic [DBGS_DW-1:0]   prdata_q,  prdata_d;   // registered read data
   logic                 pready_q,  pready_d;   // registered ready
   logic                 pslverr_q, pslverr_d;  // registered error
   dbgs_state_t          state_q,   state_d;    // sequencer state
   logic [9:0]           idx;                   // word index of paddr
   logic                 setup;                 // apb setup cycle
   logic                 wrDone;                // write completes now
   logic [1:0]           view;                  // register view field
   logic                 armBit;                // debug module armed
   logic [DBGS_NCH-1:0]  effMatch;              // enabled matches
   logic                 take2,     take3;      // decoder wants a move
   dbgs_state_t          tgt2,      tgt3;       // decoder targets

   ////////////////////////////////////////////////////////////////////////////
   // address map
   // true for every index that answers without error
   function automatic logic mapped(input logic [9:0] i);
      mapped = (i == IDX_CTRL) || (i == IDX_STATUS) || (i == IDX_SEL2) ||
               (i == IDX_SEL3) || (i == IDX_CMPEN);
   endfunction : mapped

   assign idx    = paddr[DBGS_AW-1:2];
   assign setup  = psel && !penable;
   assign wrDone = psel && penable && pready_q && pwrite;
   assign view   = ctrl_q[CTRL_VIEW_MSB:CTRL_VIEW_LSB];
   assign armBit = ctrl_q[CTRL_ARM_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // register file next values
   // reads are sampled in setup so data is a flop in the access phase
   always_comb begin
      ctrl_d    = ctrl_q;
      cmpEn_d   = cmpEn_q;
      sel2_d    = sel2_q;
      sel3_d    = sel3_q;
      prdata_d  = prdata_q;
      // ready only in the access phase, so no transfer is ever stretched
      pready_d  = setup;          // zero wait states
      pslverr_d = 1'b0;
      if (setup) begin
         pslverr_d = !mapped(idx);
         prdata_d  = '0;
         if (!pwrite) begin
            // unmapped reads return zero with an error
            if (idx == IDX_CTRL) begin
               prdata_d[7:0] = ctrl_q;
            end else if (idx == IDX_STATUS) begin
               prdata_d[1:0] = state_q;
            end else if (idx == IDX_SEL2) begin
               prdata_d[7:0] = sel2_q;
            end else if (idx == IDX_SEL3 && view == VIEW_SEL3) begin
               prdata_d[7:0] = sel3_q;
            end else if (idx == IDX_CMPEN) begin
               prdata_d[DBGS_NCH-1:0] = cmpEn_q;
            end
         end
      end
      // status is read-only: a write there completes without error and is dropped
      if (wrDone) begin
         if (idx == IDX_CTRL) begin
            ctrl_d = pwdata[7:0];
         end else if (idx == IDX_SEL2) begin
            sel2_d = pwdata[7:0];
         end else if (idx == IDX_SEL3 && view == VIEW_SEL3 && !armBit) begin
            sel3_d = pwdata[7:0];
         end else if (idx == IDX_CMPEN) begin
            cmpEn_d = pwdata[DBGS_NCH-1:0];
         end
      end
   end

   // register file flops
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_q    <= CTRL_RST;
         cmpEn_q   <= CMPEN_RST;
         sel2_q    <= SEL2_RST;
         sel3_q    <= SEL3_RST;
         prdata_q  <= '0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         ctrl_q    <= ctrl_d;
         cmpEn_q   <= cmpEn_d;
         sel2_q    <= sel2_d;
         sel3_q    <= sel3_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   // a disabled comparator can never steer the sequencer
   // matches are same-clock pulses, so no synchroniser sits on this path
   assign effMatch = matchEvent & cmpEn_q;

   dbgs_state2_decode u_dec2 (
      .code   (sel2_q[CODE_MSB:0]),
      .match  (effMatch),
      .take   (take2),
      .target (tgt2)
   );

   dbgs_state3_decode u_dec3 (
      .code   (sel3_q[CODE_MSB:0]),
      .match  (effMatch),
      .take   (take3),
      .target (tgt3)
   );

   // state next value; disarming always returns to state1
   always_comb begin
      state_d = state_q;
      if (!armBit) begin
         state_d = DBGS_STATE1;
      end else begin
         unique case (state_q)
            // state1 leaves only on an enabled channel 0 match
            DBGS_STATE1: begin
               if (effMatch[0]) begin
                  state_d = DBGS_STATE2;
               end
            end
            DBGS_STATE2: begin
               if (take2) begin
                  state_d = tgt2;
               end
            end
            DBGS_STATE3: begin
               if (take3) begin
                  state_d = tgt3;
               end
            end
            DBGS_FINAL: begin
               state_d = DBGS_FINAL;   // held until disarmed
            end
         endcase
      end
   end

   // state flop
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= DBGS_STATE1;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flops
   assign prdata   = prdata_q;
   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign seqState = state_q;
   assign armed    = ctrl_q[CTRL_ARM_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // checks
   // most checks are gated on the arm bit, since disarm forces state1
   logic inS2;
   assign inS2 = armBit && state_q == DBGS_STATE2;

   a_code5_final: assert property (@(posedge clock) disable iff (rst)
      inS2 && sel2_q[3:0] == NS2_M2_FIN && effMatch[2]
      |=> seqState == DBGS_FINAL || !armed)
      else $error("code 0101 match2 did not go final");

   a_code6_state1: assert property (@(posedge clock) disable iff (rst)
      inS2 && sel2_q[3:0] == NS2_M2S1_M0FIN && effMatch[2] && !effMatch[0]
      && !wrDone |=> seqState == DBGS_STATE1)
      else $error("code 0110 match2 did not go to state1");

   a_code7_final: assert property (@(posedge clock) disable iff (rst)
      inS2 && sel2_q[3:0] == NS2_M01_FIN && (effMatch[0] || effMatch[1])
      && !wrDone |=> seqState == DBGS_FINAL ##1 seqState == DBGS_FINAL || !armed)
      else $error("code 0111 match0/1 did not go final");

   a_code12_s3: assert property (@(posedge clock) disable iff (rst)
      inS2 && sel2_q[3:0] == NS2_M01F_M2S3 && effMatch == 3'h4 && !wrDone
      |=> seqState == DBGS_STATE3)
      else $error("code 1100 match2 did not go to state3");

   a_code15_s1: assert property (@(posedge clock) disable iff (rst)
      inS2 && sel2_q[3:0] == NS2_M01F_M2S1 && effMatch == 3'h4 && !wrDone
      |=> seqState == DBGS_STATE1)
      else $error("code 1111 match2 did not go to state1");

   a_unnamed_hold: assert property (@(posedge clock) disable iff (rst)
      inS2 && sel2_q[3:0] == NS2_M2_FIN && !effMatch[2] && !wrDone
      |=> $stable(seqState))
      else $error("unnamed match moved the sequencer");

   a_final_prio: assert property (@(posedge clock) disable iff (rst)
      inS2 && sel2_q[3:0] == NS2_M2S1_M0FIN && effMatch[0] && effMatch[2]
      && !wrDone |=> seqState == DBGS_FINAL)
      else $error("final-state match lost priority");

   a_view_read: assert property (@(posedge clock) disable iff (rst)
      psel && penable && pready && !pwrite && idx == IDX_SEL3
      && view != VIEW_SEL3 |-> prdata == '0)
      else $error("state3 select read outside its view");

   a_sel3_lock: assert property (@(posedge clock) disable iff (rst)
      wrDone && idx == IDX_SEL3 && (armBit || view != VIEW_SEL3)
      |=> $stable(sel3_q))
      else $error("locked state3 select was written");

   a_code0_s3: assert property (@(posedge clock) disable iff (rst)
      armBit && state_q == DBGS_STATE3 && sel3_q[3:0] == NS3_M0_S1
      && effMatch[0] && !wrDone |=> seqState == DBGS_STATE1)
      else $error("state3 code 0000 match0 did not go to state1");

   a_disabled_cmp: assert property (@(posedge clock) disable iff (rst)
      armBit && state_q == DBGS_STATE1 && !cmpEn_q[0] && !wrDone
      |=> seqState == DBGS_STATE1)
      else $error("disabled comparator moved the sequencer");

   a_reserved_hold: assert property (@(posedge clock) disable iff (rst)
      inS2 && sel2_q[3:2] == 2'h2 && !wrDone |=> seqState == DBGS_STATE2)
      else $error("reserved code moved the sequencer");

   // further checks: the final-going half of codes 0110, 1100 and 1111, the reserved and state3 holds, and the register gates
   a_code6_fin: assert property (@(posedge clock) disable iff (rst)
      inS2 && sel2_q[3:0] == NS2_M2S1_M0FIN && effMatch[0]
      |=> seqState == DBGS_FINAL || !armed)
      else $error("code 0110 match0 did not go final");

   a_code12_fin: assert property (@(posedge clock) disable iff (rst)
      inS2 && sel2_q[3:0] == NS2_M01F_M2S3 && (effMatch[0] || effMatch[1])
      |=> seqState == DBGS_FINAL || !armed)
      else $error("code 1100 match0/1 did not go final");

   a_code15_fin: assert property (@(posedge clock) disable iff (rst)
      inS2 && sel2_q[3:0] == NS2_M01F_M2S1 && (effMatch[0] || effMatch[1])
      |=> seqState == DBGS_FINAL || !armed)
      else $error("code 1111 match0/1 did not go final");

   a_reserved_hi: assert property (@(posedge clock) disable iff (rst)
      inS2 && (sel2_q[3:0] == 4'hD || sel2_q[3:0] == 4'hE) && !wrDone
      |=> seqState == DBGS_STATE2)
      else $error("reserved code 1101/1110 moved the sequencer");

   a_s3_hold: assert property (@(posedge clock) disable iff (rst)
      armBit && state_q == DBGS_STATE3 && sel3_q[3:0] != NS3_M0_S1 && !wrDone
      |=> seqState == DBGS_STATE3)
      else $error("undefined state3 code moved the sequencer");

   a_view_visible: assert property (@(posedge clock) disable iff (rst)
      psel && penable && pready && !pwrite && idx == IDX_SEL3
      && view == VIEW_SEL3 |-> prdata[7:0] == sel3_q)
      else $error("state3 select read wrong under its view");

   a_sel3_write: assert property (@(posedge clock) disable iff (rst)
      wrDone && idx == IDX_SEL3 && view == VIEW_SEL3 && !armBit
      |=> sel3_q == $past(pwdata[7:0]))
      else $error("open state3 select write was dropped");
endmodule : dbgs_sequencer

// File: hdl/dbgs_state2_decode.sv
/*
 * next-state choice while in state2, from the code and the enabled matches.
 * assumes matches are already gated by the comparator enables.
 */
`timescale 1ns/1ps
module dbgs_state2_decode
   import dbgs_pkg::*;
(
   input  wire logic [3:0]          code,
   input  wire logic [DBGS_NCH-1:0] match,
   output logic                     take,
   output dbgs_state_t              target
);
   // final-state matches are tested first, then lowest channel
   always_comb begin
      take   = 1'b0;
      target = DBGS_STATE2;
      case (code)
         NS2_M2_FIN: begin
            if (match[2]) begin
               take   = 1'b1;
               target = DBGS_FINAL;
            end
         end
         NS2_M2S1_M0FIN: begin
            if (match[0]) begin
               take   = 1'b1;
               target = DBGS_FINAL;
            end else if (match[2]) begin
               take   = 1'b1;
               target = DBGS_STATE1;
            end
         end
         NS2_M01_FIN: begin
            if (match[0] || match[1]) begin
               take   = 1'b1;
               target = DBGS_FINAL;
            end
         end
         NS2_M01F_M2S3: begin
            if (match[0] || match[1]) begin
               take   = 1'b1;
               target = DBGS_FINAL;
            end else if (match[2]) begin
               take   = 1'b1;
               target = DBGS_STATE3;
            end
         end
         NS2_M01F_M2S1: begin
            if (match[0] || match[1]) begin
               take   = 1'b1;
               target = DBGS_FINAL;
            end else if (match[2]) begin
               take   = 1'b1;
               target = DBGS_STATE1;
            end
         end
         // reserved and unnamed codes never move the sequencer
         default: begin
            take   = 1'b0;
         end
      endcase
   end
endmodule : dbgs_state2_decode

// File: hdl/dbgs_state3_decode.sv
/*
 * next-state choice while in state3, from the code and the enabled matches.
 * assumes matches are already gated by the comparator enables.
 */
`timescale 1ns/1ps
module dbgs_state3_decode
   import dbgs_pkg::*;
(
   input  wire logic [3:0]          code,
   input  wire logic [DBGS_NCH-1:0] match,
   output logic                     take,
   output dbgs_state_t              target
);
   // only one code is defined here; every other code holds state3
   always_comb begin
      take   = 1'b0;
      target = DBGS_STATE3;
      if (code == NS3_M0_S1 && match[0]) begin
         take   = 1'b1;
         target = DBGS_STATE1;
      end
   end
endmodule : dbgs_state3_decode

// File: test/dbgs_match_src.sv
/*
 * model of the comparator match logic that feeds the sequencer.
 * assumes the bench asks for a pattern one cycle before it should appear.
 */
`timescale 1ns/1ps
module dbgs_match_src
   import dbgs_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire logic                go,
   input  wire logic [DBGS_NCH-1:0] pat,
   output logic      [DBGS_NCH-1:0] matchEvent
);
   ////////////////////////////////////////////////////////////////////////////
   // one-cycle match pulses; idle is all zero, as real match logic would be
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         matchEvent <= '0;
      end else begin
         matchEvent <= go ? pat : '0;   // pulse only on request
      end
   end
endmodule : dbgs_match_src

// File: test/test_debug_sequencer_next_state.sv
/*
 * self-checking bench for the debug sequencer: apb tasks plus match pulses.
 * assumes the zero-wait apb slave and one-cycle state step of the note.
 */
`timescale 1ns/1ps
module test_debug_sequencer_next_state
   import dbgs_pkg::*;
;
   logic                clock, rst, psel, penable, pwrite, pready, pslverr, armed;
   logic [DBGS_AW-1:0]  paddr;
   logic [DBGS_DW-1:0]  pwdata, prdata;
   logic [DBGS_NCH-1:0] matchEvent, firePat;
   logic [1:0]          seqState;
   logic                fireGo;
   int                  err_count, compares, cyc;

   dbgs_sequencer DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .matchEvent(matchEvent),
      .seqState(seqState), .armed(armed));
   dbgs_match_src src (.clock(clock), .rst(rst), .go(fireGo), .pat(firePat),
      .matchEvent(matchEvent));

   ////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;   // a hang counts as a mismatch
         close_out();
      end
   end

   task automatic close_out();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (exp !== got) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic chk_state(input dbgs_state_t exp);
      compares++;
      if (seqState !== exp) begin
         err_count++;
         $display("CHECK FAILED seqState expected %h seen %h", exp, seqState);
      end
   endtask : chk_state

   ////////////////////////////////////////////////////////////////////////////
   // apb master: request held until pready is seen high at a rising edge
   task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic er);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge clock);
      penable <= 1'b1;
      // wait for ready; only the bench timeout ends a hung transfer
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rdat = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      logic        e;
      xfer(1'b1, idx, wd, d, e);
   endtask : wr

   task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic experr);
      logic [31:0] d;
      logic        e;
      xfer(1'b0, idx, 32'h0, d, e);
      chk("read data", exp, d);
      chk("slave error", {31'h0, experr}, {31'h0, e});
   endtask : rd

   // match pattern reaches the sequencer one edge after the request
   task automatic fire(input logic [2:0] m);
      @(posedge clock);
      fireGo  <= 1'b1;
      firePat <= m;
      @(posedge clock);
      fireGo  <= 1'b0;
      @(posedge clock);
      #1;
   endtask : fire

   // disarm, load the state2 code, arm, step into state2, then apply m
   task automatic run(input logic [3:0] c, input logic [2:0] m, input dbgs_state_t e);
      wr(IDX_CTRL, 32'h4);
      wr(IDX_SEL2, {28'h0, c});
      wr(IDX_CTRL, 32'h5);
      fire(3'h1);
      chk_state(DBGS_STATE2);
      fire(m);
      chk_state(e);
   endtask : run

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      clock = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
      fireGo = 0; firePat = '0; err_count = 0; compares = 0; cyc = 0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      rd(IDX_CTRL, 32'h0, 1'b0);
      rd(IDX_SEL2, 32'h0, 1'b0);
      rd(IDX_STATUS, 32'h0, 1'b0);
      rd(10'h100, 32'h0, 1'b1);              // unmapped index is refused
      wr(IDX_CTRL, 32'h5);
      #1;
      chk("armed", 32'h1, {31'h0, armed});
      fire(3'h7);
      chk_state(DBGS_STATE1);
      wr(IDX_CMPEN, 32'h7);
      run(4'h5, 3'h4, DBGS_FINAL);
      rd(IDX_STATUS, 32'h3, 1'b0);
      run(4'h5, 3'h3, DBGS_STATE2);
      run(4'h6, 3'h4, DBGS_STATE1);
      run(4'h6, 3'h1, DBGS_FINAL);
      run(4'h6, 3'h5, DBGS_FINAL);
      run(4'h7, 3'h1, DBGS_FINAL);
      run(4'h7, 3'h2, DBGS_FINAL);
      run(4'hC, 3'h4, DBGS_STATE3);
      run(4'hC, 3'h6, DBGS_FINAL);
      run(4'hF, 3'h4, DBGS_STATE1);
      run(4'hF, 3'h6, DBGS_FINAL);
      run(4'h8, 3'h7, DBGS_STATE2);
      run(4'hB, 3'h7, DBGS_STATE2);
      run(4'hD, 3'h7, DBGS_STATE2);
      run(4'hE, 3'h7, DBGS_STATE2);
      // state3 select: visible only under view 10, writable only under view 10, unarmed
      wr(IDX_CTRL, 32'h4);
      wr(IDX_SEL3, 32'hA);
      rd(IDX_SEL3, 32'hA, 1'b0);
      wr(IDX_CTRL, 32'h0);
      rd(IDX_SEL3, 32'h0, 1'b0);
      wr(IDX_SEL3, 32'h5);
      wr(IDX_CTRL, 32'h5);
      wr(IDX_SEL3, 32'h0);
      wr(IDX_CTRL, 32'h4);
      rd(IDX_SEL3, 32'hA, 1'b0);
      run(4'hC, 3'h4, DBGS_STATE3);
      fire(3'h1);
      chk_state(DBGS_STATE3);
      wr(IDX_CTRL, 32'h4);
      wr(IDX_SEL3, 32'h0);
      run(4'hC, 3'h4, DBGS_STATE3);
      fire(3'h6);
      chk_state(DBGS_STATE3);
      fire(3'h1);
      chk_state(DBGS_STATE1);
      close_out();
   end
endmodule : test_debug_sequencer_next_state
